// ---- shared/pwmfr_pkg.sv ----
/*
 * pwmfr_pkg: shared constants and types of the pwm trip status and
 * recovery block: register indices, field positions, reset values,
 * apb carrier structs and the recovery state type.
 * assumes a 32-bit apb with byte addresses of four times the index.
 */
package pwmfr_pkg;

   // ----------------------------------------------------------------
   // bus widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;

   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [11:0] IDX_MASK = 12'hF24;
   localparam logic [11:0] IDX_STATUS = 12'hF25;
   localparam logic [11:0] IDX_PINS = 12'hF26;
   localparam logic [11:0] IDX_CTRL = 12'hF28;
   localparam logic [11:0] IDX_IRQ_PEND = 12'hF2A;
   localparam logic [11:0] IDX_IRQ_MASK = 12'hF2B;

   // ----------------------------------------------------------------
   // status, mask and interrupt layout
   // ----------------------------------------------------------------
   localparam int BIT_RELOAD = 7;
   localparam int BIT_DEBUG = 5;
   localparam int BIT_TRIP_B = 2;
   localparam int BIT_COMP = 1;
   localparam int BIT_TRIP_A = 0;
   localparam logic [7:0] STATUS_USED = 8'hA7;
   localparam logic [7:0] FAULT_FLAGS = 8'h27;
   localparam logic [7:0] HOLD_FLAGS = 8'h07;

   // ----------------------------------------------------------------
   // control layout
   // ----------------------------------------------------------------
   localparam int BIT_DBG_RCV = 6;
   localparam int BIT_B_IRQ = 5;
   localparam int BIT_B_RCV = 4;
   localparam int BIT_C_IRQ = 3;
   localparam int BIT_C_RCV = 2;
   localparam int BIT_A_IRQ = 1;
   localparam int BIT_A_RCV = 0;
   localparam logic [7:0] CTRL_USED = 8'h7F;

   // ----------------------------------------------------------------
   // pin sample layout and reset values
   // ----------------------------------------------------------------
   localparam int BIT_PIN_TRIP_A = 6;
   localparam logic [7:0] RST_REG = 8'h00;

   // ----------------------------------------------------------------
   // carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } pwmfr_apb_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] prdata;
      logic pready;
      logic pslverr;
   } pwmfr_apb_rsp_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_FAULTED,
      ST_WAIT_RELOAD
   } pwmfr_state_t;

   // byte address of a register index
   function automatic logic [ADDR_W-1:0] pwmfr_byte_addr(
      input logic [11:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction

endpackage

// ---- rtl/pwmfr_trip_recovery.sv ----
/*
 * pwmfr_trip_recovery: trip status flags, trip masks, recovery control,
 * pin sampling and interrupt of a three-pair pwm unit, on apb.
 * assumes reload_evt is a one-cycle pulse from the pwm timer and that
 * all inputs are synchronous to ref_clk.
 */
// Chosen here: register access over APB.
`timescale 1ns/1ns

// How it works
// - reload pulse sets status bit 7, held until software clears it
// - entering debug mode sets and holds status bit 5
// - asserted secondary trip sets and holds status bit 2
// - asserted comparator trip sets and holds status bit 1
// - asserted primary trip pin sets and holds status bit 0
// - a flag clears only by writing one to its bit
// - debug automatic recovery waits for no trips and next period start
// - trip automatic recovery releases outputs once no trip is asserted
// - software recovery needs no trips, cleared flags, then a reload
// - control bit 5 enables the secondary trip interrupt
// - control bit 3 enables the comparator trip interrupt
// - control bit 1 enables the primary trip interrupt
// - pin sample bit 6 reads the live primary trip pin level
// - pin sample bits 5 to 0 read the six pwm pin levels
// - a masked trip source never sets its flag; debug entry sets bit 5 even when masked
// - clearing write to trip flag bits 2 to 0 ignored while that flag's source stays asserted
// - while faulted all six pwm outputs are forced off
module pwmfr_trip_recovery
#(
   parameter logic TRIP_A_ACTIVE = 1'b0,
   parameter logic TRIP_B_ACTIVE = 1'b0
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // register bus
   input wire pwmfr_pkg::pwmfr_apb_req_t apb_req,
   output pwmfr_pkg::pwmfr_apb_rsp_t apb_rsp,
   // trip sources
   input wire logic trip_a_pin,
   input wire logic trip_b_input,
   input wire logic comparator_trip,
   input wire logic debug_mode,
   // timer and pins
   input wire logic reload_evt,
   input wire logic [5:0] pwm_pin_level,
   // output forcing and interrupt
   output logic pwm_force_off,
   output logic irq
);
   import pwmfr_pkg::*;

   // ----------------------------------------------------------------
   // registers and state
   // ----------------------------------------------------------------
   logic [7:0] trip_mask_reg;
   logic [7:0] trip_status_reg;
   logic [7:0] trip_control_reg;
   logic [7:0] irq_pend;
   logic [7:0] irq_mask;
   logic [7:0] cause;
   logic [7:0] src_act_q;
   logic debug_q;
   logic [DATA_W-1:0] rdata_q;
   logic err_q;
   pwmfr_state_t state;
   pwmfr_state_t next_state;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   logic setup;
   logic wr;
   logic hit_mask;
   logic hit_status;
   logic hit_pins;
   logic hit_ctrl;
   logic hit_pend;
   logic hit_imask;
   logic hit_any;
   logic [7:0] wdata;

   // address match and phase strobes
   assign setup = apb_req.psel & ~apb_req.penable;
   assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign hit_mask = apb_req.paddr == pwmfr_byte_addr(IDX_MASK);
   assign hit_status = apb_req.paddr == pwmfr_byte_addr(IDX_STATUS);
   assign hit_pins = apb_req.paddr == pwmfr_byte_addr(IDX_PINS);
   assign hit_ctrl = apb_req.paddr == pwmfr_byte_addr(IDX_CTRL);
   assign hit_pend = apb_req.paddr == pwmfr_byte_addr(IDX_IRQ_PEND);
   assign hit_imask = apb_req.paddr == pwmfr_byte_addr(IDX_IRQ_MASK);
   assign hit_any = hit_mask | hit_status | hit_pins | hit_ctrl
      | hit_pend | hit_imask;
   assign wdata = apb_req.pwdata[7:0];

   // ----------------------------------------------------------------
   // trip sources
   // ----------------------------------------------------------------
   logic [7:0] src_raw;
   logic [7:0] src_act;
   logic [7:0] src_rise;
   logic debug_entry;

   // raw levels in status layout, then masked by the mask register
   assign src_raw = {2'b00, debug_mode, 2'b00,
      trip_b_input == TRIP_B_ACTIVE, comparator_trip,
      trip_a_pin == TRIP_A_ACTIVE};
   assign src_act = src_raw & ~trip_mask_reg & FAULT_FLAGS;
   assign src_rise = src_act & ~src_act_q;
   assign debug_entry = debug_mode & ~debug_q;

   // ----------------------------------------------------------------
   // status flags
   // ----------------------------------------------------------------
   logic [7:0] flag_set;
   logic [7:0] flag_clr;
   logic [7:0] next_status;

   // hardware sets win over a clearing write in the same cycle
   assign flag_set = {reload_evt, 1'b0, debug_entry, 2'b00,
      src_act[2:0]};
   assign flag_clr = (wr & hit_status) ? wdata & STATUS_USED
      & ~(src_raw & HOLD_FLAGS) : 8'h00;
   assign next_status = ((trip_status_reg & ~flag_clr) | flag_set)
      & STATUS_USED;

   // ----------------------------------------------------------------
   // interrupt pending
   // ----------------------------------------------------------------
   logic [7:0] irq_en;
   logic [7:0] irq_evt;
   logic [7:0] pend_clr;

   // trip source enables from the control register, reload and debug always enabled
   assign irq_en = {1'b1, 1'b0, 1'b1, 2'b00,
      trip_control_reg[BIT_B_IRQ],
      trip_control_reg[BIT_C_IRQ],
      trip_control_reg[BIT_A_IRQ]};
   assign irq_evt = flag_set & {3'b111, 2'b00, src_rise[2:0]}
      & irq_en;
   assign pend_clr = (wr & hit_pend) ? wdata & STATUS_USED : 8'h00;
   assign irq = |(irq_pend & irq_mask);

   // ----------------------------------------------------------------
   // recovery decision
   // ----------------------------------------------------------------
   logic [7:0] rcv_sw;
   logic [7:0] cause_all;
   logic any_src;
   logic sw_needed;
   logic flags_clear;

   // software restart bit of each source, in status layout
   assign rcv_sw = {2'b00, trip_control_reg[BIT_DBG_RCV], 2'b00,
      trip_control_reg[BIT_B_RCV], trip_control_reg[BIT_C_RCV],
      trip_control_reg[BIT_A_RCV]};
   assign cause_all = cause | src_act;
   assign any_src = |src_act;
   assign sw_needed = |(cause_all & rcv_sw);
   assign flags_clear = (trip_status_reg & FAULT_FLAGS) == 8'h00;
   assign pwm_force_off = (state != ST_IDLE) | any_src;

   // next recovery state
   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:
         begin
            if (any_src)
               next_state = ST_FAULTED;
         end
         ST_FAULTED:
         begin
            if (!any_src)
            begin
               if (sw_needed)
               begin
                  if (flags_clear)
                     next_state = ST_WAIT_RELOAD;
               end
               else if (cause_all[BIT_DEBUG])
                  next_state = ST_WAIT_RELOAD;
               else
                  next_state = ST_IDLE;
            end
         end
         ST_WAIT_RELOAD:
         begin
            if (any_src)
               next_state = ST_FAULTED;
            else if (reload_evt)
               next_state = ST_IDLE;
         end
         default:
            next_state = ST_FAULTED;
      endcase
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   logic [7:0] pins_val;
   logic [7:0] rd_val;

   // live pin levels, primary trip pin above the six pwm pins
   assign pins_val = {1'b0, trip_a_pin, pwm_pin_level};
   assign rd_val = hit_mask ? trip_mask_reg & FAULT_FLAGS
      : hit_status ? trip_status_reg
      : hit_pins ? pins_val
      : hit_ctrl ? trip_control_reg
      : hit_pend ? irq_pend
      : hit_imask ? irq_mask
      : 8'h00;

   // ----------------------------------------------------------------
   // flip-flops
   // ----------------------------------------------------------------

   // software written registers
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         trip_mask_reg <= RST_REG;
         trip_control_reg <= RST_REG;
         irq_mask <= RST_REG;
      end
      else if (wr)
      begin
         if (hit_mask)
            trip_mask_reg <= wdata & FAULT_FLAGS;
         if (hit_ctrl)
            trip_control_reg <= wdata & CTRL_USED;
         if (hit_imask)
            irq_mask <= wdata & STATUS_USED;
      end
   end

   // sticky flags and source history
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         trip_status_reg <= RST_REG;
         irq_pend <= RST_REG;
         src_act_q <= 8'h00;
         debug_q <= 1'b0;
      end
      else
      begin
         trip_status_reg <= next_status;
         irq_pend <= (irq_pend & ~pend_clr) | irq_evt;
         src_act_q <= src_act;
         debug_q <= debug_mode;
      end
   end

   // recovery state and latched fault causes
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state <= ST_IDLE;
         cause <= 8'h00;
      end
      else
      begin
         state <= next_state;
         cause <= (next_state == ST_IDLE) ? 8'h00 : cause_all;
      end
   end

   // read data captured in the setup cycle, answered with no wait
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rdata_q <= '0;
         err_q <= 1'b0;
      end
      else if (setup)
      begin
         rdata_q <= {{(DATA_W-8){1'b0}}, rd_val};
         err_q <= ~hit_any;
      end
   end

   assign apb_rsp = '{prdata: rdata_q, pready: 1'b1, pslverr: err_q};

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);

   sequence quiet_fault;
      state == ST_FAULTED && !any_src;
   endsequence

   sequence pins_read;
      setup && hit_pins;
   endsequence

   reload_flag_a: assert property (
      reload_evt |=> trip_status_reg[BIT_RELOAD])
      else $error("reload flag not set after reload");

   debug_flag_a: assert property (
      debug_entry |=> trip_status_reg[BIT_DEBUG])
      else $error("debug flag not set on debug entry");

   trip_b_flag_a: assert property (
      src_act[BIT_TRIP_B] |=> trip_status_reg[BIT_TRIP_B])
      else $error("secondary trip flag not set");

   comp_flag_a: assert property (
      src_act[BIT_COMP] |=> trip_status_reg[BIT_COMP])
      else $error("comparator flag not set");

   trip_a_flag_a: assert property (
      src_act[BIT_TRIP_A] |=> trip_status_reg[BIT_TRIP_A])
      else $error("primary trip flag not set");

   clear_by_one_a: assert property (
      |($past(trip_status_reg) & ~trip_status_reg)
      |-> $past(wr && hit_status))
      else $error("flag cleared without a status write");

   debug_wait_a: assert property (
      quiet_fault ##0 (!sw_needed && cause_all[BIT_DEBUG])
      |=> state == ST_WAIT_RELOAD)
      else $error("debug recovery did not wait for period");

   auto_release_a: assert property (
      quiet_fault ##0 (!sw_needed && !cause_all[BIT_DEBUG]) ##1 !any_src
      |-> state == ST_IDLE && !pwm_force_off)
      else $error("automatic recovery did not release");

   sw_hold_a: assert property (
      quiet_fault ##0 (sw_needed && !flags_clear)
      |=> state == ST_FAULTED)
      else $error("software recovery released with flags set");

   sw_release_a: assert property (
      state == ST_WAIT_RELOAD && reload_evt && !any_src
      |=> state == ST_IDLE)
      else $error("reload did not end recovery wait");

   trip_b_irq_a: assert property (
      src_rise[BIT_TRIP_B] && !trip_control_reg[BIT_B_IRQ]
      && !irq_pend[BIT_TRIP_B] |=> !irq_pend[BIT_TRIP_B])
      else $error("secondary trip interrupt while disabled");

   comp_irq_a: assert property (
      src_rise[BIT_COMP] && trip_control_reg[BIT_C_IRQ]
      |=> irq_pend[BIT_COMP])
      else $error("comparator interrupt not raised");

   trip_a_irq_a: assert property (
      src_rise[BIT_TRIP_A] && trip_control_reg[BIT_A_IRQ]
      && irq_mask[BIT_TRIP_A] |=> irq ##1 irq)
      else $error("primary trip interrupt not raised");

   pin_sample_a: assert property (
      pins_read |=> apb_rsp.prdata[6:0]
      == {$past(trip_a_pin), $past(pwm_pin_level)})
      else $error("pin sample read wrong");

   mask_hold_a: assert property (
      !trip_status_reg[BIT_COMP] && trip_mask_reg[BIT_COMP]
      |=> !trip_status_reg[BIT_COMP])
      else $error("masked comparator set its flag");

   clear_blocked_a: assert property (
      trip_status_reg[BIT_TRIP_A] && src_raw[BIT_TRIP_A]
      |=> trip_status_reg[BIT_TRIP_A])
      else $error("trip flag cleared while source asserted");

   force_off_a: assert property (
      any_src |-> pwm_force_off ##1 pwm_force_off)
      else $error("outputs not forced off during fault");

   reserved_zero_a: assert property (
      wr && hit_status && wdata == 8'h00
      |=> trip_status_reg == $past(trip_status_reg | flag_set)
      && (trip_status_reg & ~STATUS_USED) == 8'h00)
      else $error("zero write changed status or reserved bit set");

endmodule

// ---- sim/pwmfr_stage_model.sv ----
/*
 * pwmfr_stage_model: stand-in for the gate drivers and trip sources
 * beside the trip recovery block.
 * assumes the bench calls its tasks from the ref_clk domain.
 */
`timescale 1ns/1ns

module pwmfr_stage_model
(
   // clock and forcing from the block
   input wire logic ref_clk,
   input wire logic pwm_force_off,
   // trip sources and timer
   output logic trip_a_pin,
   output logic trip_b_input,
   output logic comparator_trip,
   output logic debug_mode,
   output logic reload_evt,
   // sensed pwm pin levels
   output logic [5:0] pwm_pin_level
);

   // ----------------------------------------------------------------
   // pin levels
   // ----------------------------------------------------------------
   // gate drivers show a fixed pattern, all low once forced off
   assign pwm_pin_level = pwm_force_off ? 6'h00 : 6'h2D;

   // idle levels: both trip pins are low active, so idle high
   initial
   begin
      trip_a_pin = 1'b1;
      trip_b_input = 1'b1;
      comparator_trip = 1'b0;
      debug_mode = 1'b0;
      reload_evt = 1'b0;
   end

   // assert or release one source: 0 a, 1 b, 2 comparator, 3 debug
   task automatic set_src(input int which, input logic on);
      @(posedge ref_clk);
      case (which)
         0: trip_a_pin <= ~on;
         1: trip_b_input <= ~on;
         2: comparator_trip <= on;
         default: debug_mode <= on;
      endcase
   endtask

   // one-cycle timer reload pulse
   task automatic pulse_reload;
      @(posedge ref_clk);
      reload_evt <= 1'b1;
      @(posedge ref_clk);
      reload_evt <= 1'b0;
   endtask

endmodule

// ---- sim/tb_top.sv ----
/*
 * tb_top: self-checking bench of the trip status and recovery block.
 * assumes the stage model drives trips, reload and pin levels.
 */
`timescale 1ns/1ns

module tb_top;
   import pwmfr_pkg::*;

   // ----------------------------------------------------------------
   // signals and instances
   // ----------------------------------------------------------------
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   pwmfr_apb_req_t apb_req = '0;
   pwmfr_apb_rsp_t apb_rsp;
   logic trip_a_pin, trip_b_input, comparator_trip, debug_mode;
   logic reload_evt, pwm_force_off, irq;
   logic [5:0] pwm_pin_level;
   int num_errors = 0;
   int check_count = 0;

   always #5 ref_clk = ~ref_clk;

   pwmfr_trip_recovery uut
   (
      .ref_clk(ref_clk), .arst_n(arst_n), .apb_req(apb_req),
      .apb_rsp(apb_rsp), .trip_a_pin(trip_a_pin),
      .trip_b_input(trip_b_input), .comparator_trip(comparator_trip),
      .debug_mode(debug_mode), .reload_evt(reload_evt),
      .pwm_pin_level(pwm_pin_level), .pwm_force_off(pwm_force_off),
      .irq(irq)
   );

   pwmfr_stage_model stage
   (
      .ref_clk(ref_clk), .pwm_force_off(pwm_force_off),
      .trip_a_pin(trip_a_pin), .trip_b_input(trip_b_input),
      .comparator_trip(comparator_trip), .debug_mode(debug_mode),
      .reload_evt(reload_evt), .pwm_pin_level(pwm_pin_level)
   );

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic report_and_stop;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, got);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   // let n edges pass, then settle
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // one apb transfer, held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [11:0] idx,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge ref_clk);
      apb_req <= '{1'b1, 1'b0, wr, {2'b00, idx, 2'b00}, wd};
      @(posedge ref_clk);
      apb_req.penable <= 1'b1;
      @(posedge ref_clk);
      while (apb_rsp.pready !== 1'b1)
      begin
         n++;
         if (n > 20)
         begin
            num_errors++;
            report_and_stop;
         end
         @(posedge ref_clk);
      end
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] idx, input logic [31:0] d);
      logic [31:0] rd;
      logic e;
      apb(1'b1, idx, d, rd, e);
   endtask

   task automatic rd(input logic [11:0] idx, input logic [31:0] exp,
      input string what);
      logic [31:0] d;
      logic e;
      apb(1'b0, idx, 32'h0, d, e);
      chk(what, exp, d);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // reset values, read-only pins, unmapped address
   task automatic t_regs;
      logic [31:0] d;
      logic e;
      rd(IDX_CTRL, 32'h00, "ctrl");
      rd(IDX_STATUS, 32'h00, "status");
      wr(IDX_CTRL, 32'h55);
      rd(IDX_CTRL, 32'h55, "ctrl");
      wr(IDX_CTRL, 32'h00);
      wr(IDX_PINS, 32'hFF);
      rd(IDX_PINS, 32'h6D, "pins");
      apb(1'b0, 12'hF27, 32'h0, d, e);
      chk("pslverr", 32'h1, 32'(e));
      chk("prdata", 32'h0, d);
   endtask

   // primary trip: flag, blocked clear, auto recovery, w1c
   task automatic t_trip_a;
      stage.set_src(0, 1'b1);
      tick(2);
      chk("force_off", 32'h1, 32'(pwm_force_off));
      rd(IDX_PINS, 32'h00, "pins");
      rd(IDX_STATUS, 32'h01, "status");
      wr(IDX_STATUS, 32'h01);
      rd(IDX_STATUS, 32'h01, "status");
      stage.set_src(0, 1'b0);
      tick(2);
      chk("force_off", 32'h0, 32'(pwm_force_off));
      wr(IDX_STATUS, 32'h00);
      rd(IDX_STATUS, 32'h01, "status");
      wr(IDX_STATUS, 32'h01);
      rd(IDX_STATUS, 32'h00, "status");
   endtask

   // software recovery needs cleared flags and then a reload
   task automatic t_sw_recovery;
      wr(IDX_CTRL, 32'h01);
      stage.set_src(0, 1'b1);
      tick(2);
      stage.set_src(0, 1'b0);
      tick(3);
      chk("force_off", 32'h1, 32'(pwm_force_off));
      wr(IDX_STATUS, 32'h01);
      tick(2);
      chk("force_off", 32'h1, 32'(pwm_force_off));
      stage.pulse_reload;
      tick(2);
      chk("force_off", 32'h0, 32'(pwm_force_off));
      rd(IDX_STATUS, 32'h80, "status");
      wr(IDX_STATUS, 32'h80);
      rd(IDX_STATUS, 32'h00, "status");
      wr(IDX_CTRL, 32'h00);
   endtask

   // each trip source with its interrupt enable, then comparator and secondary disabled
   task automatic t_irq;
      logic [7:0] sbit [3] = '{8'h01, 8'h04, 8'h02};
      logic [7:0] ebit [3] = '{8'h02, 8'h20, 8'h08};
      for (int i = 0; i < 3; i++)
      begin
         wr(IDX_CTRL, {24'h0, ebit[i]});
         wr(IDX_IRQ_MASK, {24'h0, sbit[i]});
         stage.set_src(i, 1'b1);
         tick(2);
         chk("irq", 32'h1, 32'(irq));
         rd(IDX_STATUS, {24'h0, sbit[i]}, "status");
         rd(IDX_IRQ_PEND, {24'h0, 8'h80 | sbit[i]}, "pend");
         stage.set_src(i, 1'b0);
         tick(2);
         chk("force_off", 32'h0, 32'(pwm_force_off));
         wr(IDX_STATUS, {24'h0, sbit[i]});
         wr(IDX_IRQ_PEND, {24'h0, sbit[i]});
         tick(1);
         chk("irq", 32'h0, 32'(irq));
      end
      wr(IDX_CTRL, 32'h00);
      stage.set_src(2, 1'b1);
      tick(2);
      chk("irq", 32'h0, 32'(irq));
      stage.set_src(2, 1'b0);
      wr(IDX_STATUS, 32'h02);
      wr(IDX_IRQ_MASK, 32'h04);
      stage.set_src(1, 1'b1);
      tick(2);
      chk("irq", 32'h0, 32'(irq));
      stage.set_src(1, 1'b0);
      tick(2);
      wr(IDX_STATUS, 32'h04);
      wr(IDX_IRQ_MASK, 32'h00);
   endtask

   // a masked trip source neither sets its flag nor forces off
   task automatic t_mask;
      wr(IDX_MASK, 32'h06);
      stage.set_src(1, 1'b1);
      stage.set_src(2, 1'b1);
      tick(2);
      chk("force_off", 32'h0, 32'(pwm_force_off));
      rd(IDX_STATUS, 32'h00, "status");
      rd(IDX_MASK, 32'h06, "mask");
      stage.set_src(1, 1'b0);
      stage.set_src(2, 1'b0);
      wr(IDX_MASK, 32'h00);
   endtask

   // debug entry: flag, then release only at the next period start
   task automatic t_debug;
      stage.set_src(3, 1'b1);
      tick(2);
      rd(IDX_STATUS, 32'h20, "status");
      stage.set_src(3, 1'b0);
      tick(3);
      chk("force_off", 32'h1, 32'(pwm_force_off));
      stage.pulse_reload;
      tick(2);
      chk("force_off", 32'h0, 32'(pwm_force_off));
      wr(IDX_STATUS, 32'hA0);
      rd(IDX_STATUS, 32'h00, "status");
   endtask

   // mid-run reset returns registers and flags to zero
   task automatic t_reset;
      wr(IDX_CTRL, 32'h55);
      wr(IDX_MASK, 32'h04);
      stage.pulse_reload;
      @(posedge ref_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      rd(IDX_CTRL, 32'h00, "ctrl");
      rd(IDX_MASK, 32'h00, "mask");
      rd(IDX_STATUS, 32'h00, "status");
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      t_regs;
      t_trip_a;
      t_sw_recovery;
      t_irq;
      t_mask;
      t_debug;
      t_reset;
      report_and_stop;
   end

endmodule
